/* hw/pattern_loader_defs.vh */
// constants for the mirror test pattern loader
`ifndef PATTERN_LOADER_DEFS_VH
`define PATTERN_LOADER_DEFS_VH

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_BLK_ACTIVE 8'h04
`define OFF_STATUS 8'h08

// control fields
`define CTRL_GEN_EN 0
`define CTRL_CYCLE_EN 1
`define CTRL_FLIP_EN 2
`define CTRL_PAT_LO 4
`define CTRL_PAT_HI 7
`define CTRL_MODE_LO 8
`define CTRL_MODE_HI 10
`define CTRL_RESET 32'h0000_0000
`define BLK_ACTIVE_RESET 16'hffff

// pattern codes
`define PAT_ON 4'h0
`define PAT_OFF 4'h1
`define PAT_CHK 4'h2
`define PAT_GRID 4'h3
`define PAT_DIAG_WE 4'h4
`define PAT_DIAG_EW 4'h5
`define PAT_HLINES 4'h6
`define PAT_VLINES 4'h7
`define PAT_COARSE 4'h8
`define PAT_DOTS 4'h9
`define PAT_INV_CHK 4'ha
`define PAT_RANDOM 4'hb
`define PAT_H1 4'hc
`define PAT_V1 4'hd
`define PAT_TOGGLE 4'he
`define PAT_CYCLE_LAST 4'h7

// load modes
`define MODE_NORMAL 3'h0
`define MODE_CLEAR 3'h1
`define MODE_SET 3'h2
`define MODE_DOUBLE 3'h3
`define MODE_SLOW 3'h4

// array load kinds
`define KIND_DATA 2'h0
`define KIND_CLEAR 2'h1
`define KIND_SET 2'h2

// geometry and timing
`define CHK_BIT 6
`define COARSE_BIT 5
`define LINE_BIT 3
`define DIAG_MASK 16'h000f
`define DOT_PITCH 10
`define DOUBLE_MAX_LINES 68
`define SEG_LAST 2'h3
`define LANES_ALL 12'hfff
`define LANES_ONE 12'h00f
`define LFSR_SEED 16'hace1
`define LFSR_TAPS 16'hb400
`define HOLD_MS 2000
`define CLK_KHZ 10000

`endif

/* hw/mirror_test_pattern_loader.v */
// mirror test pattern loader with apb register slave
`timescale 1ns/1ps
`include "pattern_loader_defs.vh"

module mirror_test_pattern_loader #(
   parameter SEG_W = 32,
   parameter BLK_ROWS = 136,
   parameter NBLK = 16,
   parameter HOLD_CYCLES = `HOLD_MS * `CLK_KHZ,
   parameter HOLD_W = 25
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // line stream to the array controller
   output reg [4*SEG_W-1:0] line_data,
   output reg line_valid,
   output reg [15:0] line_row,
   output reg [1:0] line_seg,
   output reg [11:0] lane_en,
   // block commands
   output reg cmd_valid,
   output reg array_load,
   output reg [1:0] load_kind,
   output reg double_row_load,
   output reg mirror_reset_trigger,
   output reg [3:0] block_idx
);

   localparam LINE_W = 4 * SEG_W;
   localparam [15:0] ROWS = NBLK * BLK_ROWS;
   localparam [15:0] COLS = LINE_W;
   localparam [15:0] DBL_LINES = (BLK_ROWS / 2 > `DOUBLE_MAX_LINES) ?
      `DOUBLE_MAX_LINES : BLK_ROWS / 2;
   localparam [15:0] FULL_LINES = BLK_ROWS;
   localparam [HOLD_W-1:0] HOLD_LAST = HOLD_CYCLES - 1;

   localparam ST_IDLE = 3'd0;
   localparam ST_FIND = 3'd1;
   localparam ST_CMD = 3'd2;
   localparam ST_SEND = 3'd3;
   localparam ST_LOAD = 3'd4;
   localparam ST_TRIG = 3'd5;

   reg [31:0] ctrl_r;
   reg [15:0] blk_active_r;
   reg [2:0] state_r;
   reg [3:0] blk_r;
   reg [15:0] line_r;
   reg [1:0] seg_r;
   reg [3:0] pat_r;
   reg [2:0] mode_r;
   reg tog_r;
   reg [3:0] cyc_pat_r;
   reg [HOLD_W-1:0] hold_r;
   reg [15:0] lfsr_r;

   wire gen_en = ctrl_r[`CTRL_GEN_EN];
   wire cycle_en = ctrl_r[`CTRL_CYCLE_EN];
   wire flip_en = ctrl_r[`CTRL_FLIP_EN];
   wire [3:0] pat_sel = ctrl_r[`CTRL_PAT_HI:`CTRL_PAT_LO];
   wire [2:0] mode_sel = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];

   // pixel value at column x, row y
   function pix;
      input [15:0] x;
      input [15:0] y;
      input [3:0] pat;
      input tog;
      input rnd;
      reg [15:0] s;
      begin
         s = x + y;
         case (pat)
            `PAT_ON: pix = 1'b1;
            `PAT_OFF: pix = 1'b0;
            `PAT_CHK: pix = x[`CHK_BIT] ^ y[`CHK_BIT];
            `PAT_GRID: pix = (x == 16'h0000) || (y == 16'h0000) ||
               (x == COLS - 16'h0001) || (y == ROWS - 16'h0001);
            `PAT_DIAG_WE: pix = ((x - y) & `DIAG_MASK) == 16'h0000;
            `PAT_DIAG_EW: pix = (s & `DIAG_MASK) == 16'h0000;
            `PAT_HLINES: pix = y[`LINE_BIT];
            `PAT_VLINES: pix = x[`LINE_BIT];
            `PAT_COARSE: pix = x[`COARSE_BIT] ^ y[`COARSE_BIT];
            `PAT_DOTS: pix = (x % `DOT_PITCH == 0) &&
               (y % `DOT_PITCH == 0);
            `PAT_INV_CHK: pix = ~(x[`CHK_BIT] ^ y[`CHK_BIT]);
            `PAT_RANDOM: pix = rnd;
            `PAT_H1: pix = y[0];
            `PAT_V1: pix = x[0];
            `PAT_TOGGLE: pix = tog;
            default: pix = 1'b0;
         endcase
      end
   endfunction

   // image row feeding the current line
   localparam [15:0] BLK_ROWS_W = BLK_ROWS;
   wire [15:0] blk_base = {12'h000, blk_r} * BLK_ROWS_W;
   wire [15:0] line_off = (mode_r == `MODE_DOUBLE) ?
      {line_r[14:0], 1'b0} : line_r;
   wire [15:0] arr_row = blk_base + line_off;
   wire [15:0] img_row = flip_en ? (ROWS - 16'h0001 - arr_row) :
      arr_row;

   wire [LINE_W-1:0] full_line;
   genvar g;
   generate
      for (g = 0; g < LINE_W; g = g + 1) begin : g_pix
         wire [15:0] gx = g;
         assign full_line[g] = pix(gx, img_row, pat_r, tog_r,
            lfsr_r[gx[3:0]] ^ img_row[gx[3:0]]);
      end
   endgenerate

   // slow mode carries one segment on the low lanes
   wire [LINE_W-1:0] seg_shift = full_line >> (seg_r * SEG_W);
   wire [LINE_W-1:0] slow_line = {{(LINE_W-SEG_W){1'b0}},
      seg_shift[SEG_W-1:0]};
   wire slow = (mode_r == `MODE_SLOW);
   wire [15:0] lines_last = ((mode_r == `MODE_DOUBLE) ? DBL_LINES :
      FULL_LINES) - 16'h0001;

   // whether block blk_r is active
   wire blk_on = blk_active_r[blk_r];

   // pattern cycling timer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_r <= {HOLD_W{1'b0}};
         cyc_pat_r <= 4'h0;
         lfsr_r <= `LFSR_SEED;
      end else begin
         lfsr_r <= {lfsr_r[14:0], ^(lfsr_r & `LFSR_TAPS)};
         if (!cycle_en) begin
            hold_r <= {HOLD_W{1'b0}};
            cyc_pat_r <= 4'h0;
         end else if (hold_r == HOLD_LAST) begin
            hold_r <= {HOLD_W{1'b0}};
            cyc_pat_r <= (cyc_pat_r == `PAT_CYCLE_LAST) ? 4'h0 :
               cyc_pat_r + 4'h1;
         end else begin
            hold_r <= hold_r + {{(HOLD_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // frame sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         blk_r <= 4'h0;
         line_r <= 16'h0000;
         seg_r <= 2'h0;
         pat_r <= 4'h0;
         mode_r <= `MODE_NORMAL;
         tog_r <= 1'b0;
         line_data <= {LINE_W{1'b0}};
         line_valid <= 1'b0;
         line_row <= 16'h0000;
         line_seg <= 2'h0;
         lane_en <= 12'h000;
         cmd_valid <= 1'b0;
         array_load <= 1'b0;
         load_kind <= `KIND_DATA;
         double_row_load <= 1'b0;
         mirror_reset_trigger <= 1'b0;
         block_idx <= 4'h0;
      end else begin
         line_valid <= 1'b0;
         cmd_valid <= 1'b0;
         array_load <= 1'b0;
         mirror_reset_trigger <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               blk_r <= 4'h0;
               if (gen_en) begin
                  pat_r <= cycle_en ? cyc_pat_r : pat_sel;
                  mode_r <= mode_sel;
                  tog_r <= ~tog_r;
                  state_r <= ST_FIND;
               end
            end
            ST_FIND: begin
               line_r <= 16'h0000;
               seg_r <= slow ? `SEG_LAST : 2'h0;
               if (!gen_en) begin
                  state_r <= ST_IDLE;
               end else if (blk_on) begin
                  block_idx <= blk_r;
                  double_row_load <= (mode_r == `MODE_DOUBLE);
                  if (mode_r == `MODE_CLEAR || mode_r == `MODE_SET)
                     state_r <= ST_LOAD;
                  else
                     state_r <= ST_CMD;
               end else if (blk_r == NBLK - 1) begin
                  state_r <= ST_IDLE;
               end else begin
                  blk_r <= blk_r + 4'h1;
               end
            end
            ST_CMD: begin
               cmd_valid <= 1'b1;
               state_r <= ST_SEND;
            end
            ST_SEND: begin
               line_valid <= 1'b1;
               line_row <= arr_row;
               line_seg <= seg_r;
               line_data <= slow ? slow_line : full_line;
               lane_en <= slow ? `LANES_ONE : `LANES_ALL;
               if (slow && seg_r != 2'h0) begin
                  seg_r <= seg_r - 2'h1;
               end else begin
                  seg_r <= slow ? `SEG_LAST : 2'h0;
                  if (line_r == lines_last)
                     state_r <= ST_LOAD;
                  else
                     line_r <= line_r + 16'h0001;
               end
            end
            ST_LOAD: begin
               array_load <= 1'b1;
               load_kind <= (mode_r == `MODE_CLEAR) ? `KIND_CLEAR :
                  (mode_r == `MODE_SET) ? `KIND_SET :
                  `KIND_DATA;
               state_r <= ST_TRIG;
            end
            ST_TRIG: begin
               mirror_reset_trigger <= 1'b1;
               if (blk_r == NBLK - 1) begin
                  state_r <= ST_IDLE;
               end else begin
                  blk_r <= blk_r + 4'h1;
                  state_r <= ST_FIND;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // apb slave, one wait state
   wire acc = psel && penable;
   wire hit = (paddr == `OFF_CTRL) || (paddr == `OFF_BLK_ACTIVE) ||
      (paddr == `OFF_STATUS);
   reg [31:0] rd_nxt;
   always @* begin
      case (paddr)
         `OFF_CTRL: rd_nxt = ctrl_r;
         `OFF_BLK_ACTIVE: rd_nxt = {16'h0000, blk_active_r};
         `OFF_STATUS: rd_nxt = {16'h0000, 1'b0, state_r, blk_r, pat_r,
            3'h0, state_r != ST_IDLE};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `CTRL_RESET;
         blk_active_r <= `BLK_ACTIVE_RESET;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= acc && !pready;
         if (acc && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= !hit;
         end
         if (acc && pready && pwrite) begin
            if (paddr == `OFF_CTRL)
               ctrl_r <= pwdata;
            if (paddr == `OFF_BLK_ACTIVE)
               blk_active_r <= pwdata[15:0];
         end
      end
   end

endmodule // mirror_test_pattern_loader

/* test/mirror_loader_sva.sv */
// assertions on the loader's stream outputs
`timescale 1ns/1ps
module loader_checker (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // stream and commands
   input wire line_valid,
   input wire [15:0] line_row,
   input wire [1:0] line_seg,
   input wire [11:0] lane_en,
   input wire cmd_valid,
   input wire array_load,
   input wire [1:0] load_kind,
   input wire double_row_load,
   input wire mirror_reset_trigger
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [15:0] beat_cnt_r;
   logic [15:0] beat_cnt_nxt;
   // beats since the last command
   always @* beat_cnt_nxt = cmd_valid ? 16'h0000 : beat_cnt_r + {15'h0000, line_valid};
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         beat_cnt_r <= 16'h0000;
      end else begin
         beat_cnt_r <= beat_cnt_nxt;
      end
   end
   sequence s_cmd_line;
      cmd_valid ##1 line_valid;
   endsequence
   sequence s_load_trig;
      array_load ##1 mirror_reset_trigger;
   endsequence
   a_cmd_opens_lines: assert property (cmd_valid |-> s_cmd_line)
      else $error("no line after command");
   a_load_then_trig: assert property (array_load |-> s_load_trig)
      else $error("no trigger after load");
   a_trig_has_load: assert property (mirror_reset_trigger |-> $past(array_load))
      else $error("trigger without load");
   a_bare_load: assert property ((array_load && load_kind != 2'h0) |-> !$past(line_valid) && !$past(cmd_valid))
      else $error("data before clear or set");
   a_double_max: assert property ((array_load && double_row_load && load_kind == 2'h0) |-> beat_cnt_r <= 16'h0044)
      else $error("too many double lines");
   a_double_pairs: assert property ((line_valid && double_row_load) |-> !line_row[0])
      else $error("odd row in double load");
   a_slow_lanes: assert property ((line_valid && line_seg != 2'h0) |-> lane_en == 12'h00f)
      else $error("segment on wide lanes");
   a_seg_order: assert property ((line_valid && line_seg != 2'h0) |=> line_valid && line_seg == $past(line_seg) - 2'h1)
      else $error("segment order");
   a_slow_last: assert property ((array_load && lane_en == 12'h00f && load_kind == 2'h0) |-> $past(line_valid) && $past(line_seg) == 2'h0)
      else $error("slow load before last segment");
endmodule // loader_checker

/* test/mirror_array_model.sv */
// array controller model that counts and checks lines
`timescale 1ns/1ps
module mirror_array_model #(parameter ROWS = 128) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // stream from the loader
   input wire [127:0] line_data,
   input wire line_valid,
   input wire [15:0] line_row,
   input wire [11:0] lane_en,
   input wire cmd_valid,
   input wire mirror_reset_trigger,
   input wire [3:0] block_idx,
   // bench side
   input wire clr,
   input wire [3:0] exp_pat,
   input wire exp_flip,
   output integer beats,
   output integer cmds,
   output integer trigs,
   output integer bad,
   output logic [3:0] trig_blk
);
   function automatic logic [127:0] exp_line(input int y, input logic [3:0] p);
      logic [127:0] v;
      for (int x = 0; x < 128; x++) begin
         case (p)
            4'h0: v[x] = 1'b1;
            4'h1: v[x] = 1'b0;
            4'h2: v[x] = x[6] ^ y[6];
            4'h3: v[x] = (x == 0) || (y == 0) || (x == 127) ||
               (y == ROWS - 1);
            4'h8: v[x] = x[5] ^ y[5];
            4'h9: v[x] = (x % 10 == 0) && (y % 10 == 0);
            4'ha: v[x] = ~(x[6] ^ y[6]);
            4'hc: v[x] = y[0];
            4'hd: v[x] = x[0];
            default: v[x] = line_data[x];
         endcase
      end
      return v;
   endfunction
   always @(posedge pclk or negedge presetn) begin
      if (!presetn || clr) begin
         beats <= 0;
         cmds <= 0;
         trigs <= 0;
         bad <= 0;
         trig_blk <= 4'h0;
      end else begin
         beats <= beats + line_valid;
         cmds <= cmds + cmd_valid;
         if (mirror_reset_trigger) begin
            trigs <= trigs + 1;
            trig_blk <= block_idx;
         end
         // wide lanes carry whole lines, flip mirrors the rows
         if (line_valid && lane_en == 12'hfff && line_data !== exp_line(exp_flip ? ROWS - 1 - line_row : line_row, exp_pat))
            bad <= bad + 1;
      end
   end
endmodule // mirror_array_model

/* test/test_mirror_test_pattern_loader.sv */
// bench for the mirror test pattern loader
`timescale 1ns/1ps
`include "pattern_loader_defs.vh"
module test_mirror_test_pattern_loader;
   localparam int BR = 8;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, line_valid, cmd_valid, array_load;
   wire double_row_load, mirror_reset_trigger;
   wire [127:0] line_data;
   wire [15:0] line_row;
   wire [1:0] line_seg, load_kind;
   wire [11:0] lane_en;
   wire [3:0] block_idx;
   logic clr = 1'b0;
   logic [3:0] exp_pat = 4'h0;
   logic exp_flip = 1'b0;
   integer beats, cmds, trigs, bad;
   logic [3:0] trig_blk;
   integer err_count = 0;
   integer checked = 0;
   logic [31:0] rd;
   logic err;
   logic [1:0] last_kind = 2'h0;
   logic tog_bit = 1'b0;
   logic tog_prev = 1'b0;
   logic [15:0] seen = 16'h0000;
   // last load kind and last pixel seen on the stream
   always @(posedge pclk) begin
      if (array_load) last_kind <= load_kind;
      if (line_valid) tog_bit <= line_data[0];
   end
   logic [3:0] pats [8] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd};
   always #50 pclk = ~pclk;
   mirror_test_pattern_loader #(.BLK_ROWS(BR), .HOLD_CYCLES(50)) dut_u (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .line_data, .line_valid, .line_row, .line_seg,
      .lane_en, .cmd_valid, .array_load, .load_kind, .double_row_load,
      .mirror_reset_trigger, .block_idx);
   mirror_array_model #(.ROWS(16 * BR)) model_u (.pclk, .presetn, .line_data,
      .line_valid, .line_row, .lane_en, .cmd_valid, .mirror_reset_trigger,
      .block_idx, .clr, .exp_pat, .exp_flip, .beats, .cmds, .trigs, .bad,
      .trig_blk);
   task automatic results;
      if (err_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         results();
      end
   endtask
   // one frame on block 2 only, then generator off
   task automatic run(input logic [31:0] ctrl, input integer nb, input integer nc);
      integer n;
      n = 0;
      exp_pat <= ctrl[7:4];
      exp_flip <= ctrl[2];
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      apb(1'b1, 8'h04, 32'h0000_0004);
      apb(1'b1, 8'h00, ctrl);
      if (ctrl[0]) begin
         while (trigs < 1 && n < 3000) begin
            @(posedge pclk);
            n++;
         end
      end
      if (n >= 3000) begin
         err_count++;
         results();
      end
      apb(1'b1, 8'h00, 32'h0);
      repeat (60) @(posedge pclk);
      chk(beats, nb);
      chk(cmds, nc);
      chk(trigs, {31'h0, ctrl[0]});
      chk(bad, 0);
      if (ctrl[0]) chk({28'h0, trig_blk}, 2);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, `CTRL_RESET);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, {16'h0, `BLK_ACTIVE_RESET});
      apb(1'b1, 8'h0c, 32'hffff_ffff);
      chk({31'h0, err}, 1);
      apb(1'b0, 8'h0c, 32'h0);
      chk({31'h0, err}, 1);
      chk(rd, 0);
      foreach (pats[i]) run({24'h0, pats[i], 4'h1}, BR, 1);
      run(32'h0000_0025, BR, 1);
      run(32'h0000_0020, 0, 0);
      run(32'h0000_0101, 0, 0);
      chk({30'h0, last_kind}, {30'h0, `KIND_CLEAR});
      run(32'h0000_0201, 0, 0);
      chk({30'h0, last_kind}, {30'h0, `KIND_SET});
      run(32'h0000_0321, BR / 2, 1);
      chk({31'h0, double_row_load}, 1);
      run(32'h0000_0411, 4 * BR, 1);
      run(32'h0000_0031, BR, 1);
      run(32'h0000_00e1, BR, 1);
      tog_prev = tog_bit;
      run(32'h0000_00e1, BR, 1);
      chk({31'h0, tog_bit ^ tog_prev}, 1);
      // cycling must visit patterns 0 to 7 and nothing else
      seen = 16'h0000;
      apb(1'b1, `OFF_CTRL, 32'h0000_0003);
      repeat (150) begin
         apb(1'b0, `OFF_STATUS, 32'h0);
         seen[rd[7:4]] = 1'b1;
      end
      apb(1'b1, `OFF_CTRL, 32'h0);
      chk({16'h0, seen}, 32'h0000_00ff);
      results();
   end
endmodule // test_mirror_test_pattern_loader
bind mirror_test_pattern_loader loader_checker chk_u (.pclk(pclk),
   .presetn(presetn), .line_valid(line_valid), .line_row(line_row),
   .line_seg(line_seg), .lane_en(lane_en), .cmd_valid(cmd_valid),
   .array_load(array_load), .load_kind(load_kind),
   .double_row_load(double_row_load),
   .mirror_reset_trigger(mirror_reset_trigger));
